// *** logic/oms_top.v ***
// Optical module transmit/receive control, status byte and management pages
// Overview of operation
// - Transmit-off high disables laser, low transmits
// - Cycling transmit-off after fault clears the latched fault
// - Undriven transmit-off input reads as high
// - Soft transmit-off writable at byte 110 bit 6
// - Transmit-off state readable at bit 7
// - Hardware and soft transmit-off combine by OR
// - Laser fault asserts fault output, disables laser
// - Fault output open collector, high means fault
// - Fault latched, cleared by toggle or power
// - Fault mirrored at byte 110 bit 2
// - Signal-lost high when no transitions seen
// - Signal-lost mirrored at byte 110 bit 1
// - Identification page answers at address A0
// - Diagnostic page answers at address A2
// - Live monitors readable in diagnostic page
`include "oms_regs.vh"

module oms_top (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Transmit-off pin, level plus whether the host drives it
   input wire tx_off_level,
   input wire tx_off_driven,
   // Laser fault detector and laser control
   input wire laser_fault_detect,
   output reg laser_enable,
   // Open-collector fault pin
   output reg tx_fault_out,
   output reg tx_fault_oe_n,
   // Receive path
   input wire rx_data,
   output reg receive_signal_lost,
   // Live monitor values
   input wire [15:0] mon_temp,
   input wire [15:0] mon_vcc,
   input wire [15:0] mon_bias,
   input wire [15:0] mon_tx_power,
   input wire [15:0] mon_rx_power,
   // Two-wire management bus
   input wire scl_in,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe_n
);

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   reg [1:0] rst_pipe;
   wire rst_sync_n = rst_pipe[1];

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_pipe <= 2'b00;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Pull-up: an undriven pin is seen as high before it enters the chain
   wire tx_off_pin = tx_off_level | ~tx_off_driven;
   reg [1:0] off_sync;
   reg [1:0] flt_sync;
   reg [1:0] rx_sync;
   reg [1:0] scl_sync;
   reg [1:0] sda_sync;

   // Start high so the transmitter stays off until the host pulls low
   always @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         off_sync <= 2'b11;
         flt_sync <= 2'b00;
         rx_sync <= 2'b00;
         scl_sync <= 2'b11;
         sda_sync <= 2'b11;
      end else begin
         off_sync <= {off_sync[0], tx_off_pin};
         flt_sync <= {flt_sync[0], laser_fault_detect};
         rx_sync <= {rx_sync[0], rx_data};
         scl_sync <= {scl_sync[0], scl_in};
         sda_sync <= {sda_sync[0], sda_in};
      end
   end

   wire hw_off = off_sync[1];
   wire fault_now = flt_sync[1];

   // ----------------------------------------------------------------
   // Transmit-off and latched fault
   // ----------------------------------------------------------------
   reg hw_off_q;
   reg soft_off;
   reg fault_latch;
   wire hw_off_toggle = hw_off ^ hw_off_q;
   wire wr_en;
   wire wr_page;
   wire [7:0] wr_ptr;
   wire [7:0] wr_data;
   wire cs_write = wr_en & (wr_page == `OMS_PAGE_DIAG) & (wr_ptr == `OMS_CTRL_STATUS);

   // A persisting fault re-latches at once: set wins over the toggle clear
   always @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         hw_off_q <= 1'b1;
         soft_off <= `OMS_SOFT_OFF_RESET;
         fault_latch <= 1'b0;
      end else begin
         hw_off_q <= hw_off;
         if (cs_write) begin
            soft_off <= wr_data[`OMS_CS_SOFT_OFF];
         end
         if (fault_now) begin
            fault_latch <= 1'b1;
         end else if (hw_off_toggle) begin
            fault_latch <= 1'b0;
         end
      end
   end

   // Laser runs only with both disables low and no latched fault
   wire next_laser_enable = ~(hw_off | soft_off) & ~fault_latch & ~fault_now;

   // ----------------------------------------------------------------
   // Receive transition detector
   // ----------------------------------------------------------------
   // Only edges count, so a stuck-high or stuck-low input is lost signal
   localparam integer LOST_N = `OMS_LOST_CYCLES;
   localparam [`OMS_LOST_CNT_W-1:0] LOST_MAX = LOST_N[`OMS_LOST_CNT_W-1:0];
   reg rx_q;
   reg [`OMS_LOST_CNT_W-1:0] quiet_cnt;
   wire rx_edge = rx_sync[1] ^ rx_q;
   wire quiet_full = (quiet_cnt == LOST_MAX);

   // Reset counts as already quiet, so no false good-signal shows before an edge
   always @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rx_q <= 1'b0;
         quiet_cnt <= LOST_MAX;
      end else begin
         rx_q <= rx_sync[1];
         if (rx_edge) begin
            quiet_cnt <= {`OMS_LOST_CNT_W{1'b0}};
         end else if (!quiet_full) begin
            quiet_cnt <= quiet_cnt + {{(`OMS_LOST_CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // ----------------------------------------------------------------
   // Pin outputs, all registered
   // ----------------------------------------------------------------
   wire sda_pull;

   // Fault pin released (pulled high by host) only while a fault is latched
   always @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         laser_enable <= 1'b0;
         tx_fault_out <= 1'b0;
         tx_fault_oe_n <= 1'b0;
         receive_signal_lost <= 1'b1;
         sda_out <= 1'b0;
         sda_oe_n <= 1'b1;
      end else begin
         laser_enable <= next_laser_enable;
         tx_fault_out <= 1'b0;
         tx_fault_oe_n <= fault_latch | fault_now;
         receive_signal_lost <= quiet_full & ~rx_edge;
         sda_out <= 1'b0;
         sda_oe_n <= ~sda_pull;
      end
   end

   // ----------------------------------------------------------------
   // Management pages
   // ----------------------------------------------------------------
   reg [7:0] id_mem [0:255];
   reg [7:0] diag_mem [0:255];

   // Writable byte storage of both pages, one flip-flop byte per entry
   genvar gi;
   generate
      for (gi = 0; gi < 256; gi = gi + 1) begin : g_mem
         localparam [7:0] IDX = gi;
         always @(posedge clk or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
               id_mem[gi] <= `OMS_MEM_RESET;
               diag_mem[gi] <= `OMS_MEM_RESET;
            end else if (wr_en && wr_ptr == IDX) begin
               if (wr_page == `OMS_PAGE_ID) begin
                  id_mem[gi] <= wr_data;
               end else begin
                  diag_mem[gi] <= wr_data;
               end
            end
         end
      end
   endgenerate

   // Status byte; unlisted bits read as zero
   reg [7:0] cs_byte;
   always @* begin
      cs_byte = 8'h00;
      cs_byte[`OMS_CS_HW_OFF] = hw_off;
      cs_byte[`OMS_CS_SOFT_OFF] = soft_off;
      cs_byte[`OMS_CS_FAULT] = fault_latch;
      cs_byte[`OMS_CS_LOST] = receive_signal_lost;
   end

   // Read mux; monitors are live so two halves may come from different samples
   reg [7:0] rd_data;
   always @* begin
      rd_data = 8'h00;
      if (wr_page == `OMS_PAGE_ID) begin
         rd_data = id_mem[wr_ptr];
      end else begin
         case (wr_ptr)
            `OMS_TEMP_MSB: rd_data = mon_temp[15:8];
            `OMS_TEMP_LSB: rd_data = mon_temp[7:0];
            `OMS_VCC_MSB: rd_data = mon_vcc[15:8];
            `OMS_VCC_LSB: rd_data = mon_vcc[7:0];
            `OMS_BIAS_MSB: rd_data = mon_bias[15:8];
            `OMS_BIAS_LSB: rd_data = mon_bias[7:0];
            `OMS_TXPWR_MSB: rd_data = mon_tx_power[15:8];
            `OMS_TXPWR_LSB: rd_data = mon_tx_power[7:0];
            `OMS_RXPWR_MSB: rd_data = mon_rx_power[15:8];
            `OMS_RXPWR_LSB: rd_data = mon_rx_power[7:0];
            `OMS_CTRL_STATUS: rd_data = cs_byte;
            default: rd_data = diag_mem[wr_ptr];
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Two-wire slave
   // ----------------------------------------------------------------
   oms_twowire u_twowire (
      .clk(clk),
      .rst_sync_n(rst_sync_n),
      .scl_s(scl_sync[1]),
      .sda_s(sda_sync[1]),
      .sda_pull(sda_pull),
      .page(wr_page),
      .ptr(wr_ptr),
      .wr_en(wr_en),
      .wr_data(wr_data),
      .rd_data(rd_data)
   );

endmodule

// *** logic/oms_regs.vh ***
// Constants for the optical module control, status and management block
`ifndef OMS_REGS_VH
`define OMS_REGS_VH

// ----------------------------------------------------------------
// Two-wire device addresses (7-bit form of the 8-bit codes)
// ----------------------------------------------------------------
`define OMS_DEV_ID 7'h50
`define OMS_DEV_DIAG 7'h51
`define OMS_PAGE_ID 1'b0
`define OMS_PAGE_DIAG 1'b1

// ----------------------------------------------------------------
// Diagnostic page layout
// ----------------------------------------------------------------
`define OMS_TEMP_MSB 8'h60
`define OMS_TEMP_LSB 8'h61
`define OMS_VCC_MSB 8'h62
`define OMS_VCC_LSB 8'h63
`define OMS_BIAS_MSB 8'h64
`define OMS_BIAS_LSB 8'h65
`define OMS_TXPWR_MSB 8'h66
`define OMS_TXPWR_LSB 8'h67
`define OMS_RXPWR_MSB 8'h68
`define OMS_RXPWR_LSB 8'h69
`define OMS_CTRL_STATUS 8'h6e

// Fields of the control/status byte
`define OMS_CS_HW_OFF 7
`define OMS_CS_SOFT_OFF 6
`define OMS_CS_FAULT 2
`define OMS_CS_LOST 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define OMS_MEM_RESET 8'h00
`define OMS_SOFT_OFF_RESET 1'b0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define OMS_CLK_PERIOD_NS 10
`define OMS_LOST_TIME_NS 1000
`define OMS_LOST_CYCLES (`OMS_LOST_TIME_NS / `OMS_CLK_PERIOD_NS)
`define OMS_LOST_CNT_W 8

`endif

// *** logic/oms_twowire.v ***
// Two-wire management slave serving the identification and diagnostic pages
`include "oms_regs.vh"

module oms_twowire (
   // Clock and reset
   input wire clk,
   input wire rst_sync_n,
   // Synchronised bus lines
   input wire scl_s,
   input wire sda_s,
   // Open-drain data drive request
   output reg sda_pull,
   // Memory access
   output reg page,
   output reg [7:0] ptr,
   output reg wr_en,
   output reg [7:0] wr_data,
   input wire [7:0] rd_data
);

   localparam ST_IDLE = 3'd0;
   localparam ST_ADDR = 3'd1;
   localparam ST_PTR = 3'd2;
   localparam ST_WDATA = 3'd3;
   localparam ST_ACK = 3'd4;
   localparam ST_RDATA = 3'd5;
   localparam ST_RACK = 3'd6;

   reg [2:0] state;
   reg [2:0] ret_state;
   reg [3:0] bitcnt;
   reg [7:0] shreg;
   reg scl_q;
   reg sda_q;

   wire scl_rise = scl_s & ~scl_q;
   wire scl_fall = ~scl_s & scl_q;
   wire start_cond = scl_s & scl_q & sda_q & ~sda_s;
   wire stop_cond = scl_s & scl_q & ~sda_q & sda_s;
   wire addr_hit = (shreg[7:1] == `OMS_DEV_ID) | (shreg[7:1] == `OMS_DEV_DIAG);

   // ----------------------------------------------------------------
   // Byte engine: data sampled on the rising clock, driven on the falling
   // ----------------------------------------------------------------
   always @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state <= ST_IDLE;
         ret_state <= ST_IDLE;
         bitcnt <= 4'h0;
         shreg <= 8'h00;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         sda_pull <= 1'b0;
         page <= 1'b0;
         ptr <= 8'h00;
         wr_en <= 1'b0;
         wr_data <= 8'h00;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
         wr_en <= 1'b0;
         if (start_cond) begin
            // Repeated start is accepted at any point
            state <= ST_ADDR;
            bitcnt <= 4'h0;
            sda_pull <= 1'b0;
         end else if (stop_cond) begin
            state <= ST_IDLE;
            sda_pull <= 1'b0;
         end else begin
            case (state)
               ST_ADDR, ST_PTR, ST_WDATA: begin
                  if (scl_rise && bitcnt != 4'h8) begin
                     shreg <= {shreg[6:0], sda_s};
                     bitcnt <= bitcnt + 4'h1;
                  end else if (scl_fall && bitcnt == 4'h8) begin
                     bitcnt <= 4'h0;
                     if (state == ST_ADDR) begin
                        if (addr_hit) begin
                           page <= shreg[1];
                           sda_pull <= 1'b1;
                           state <= ST_ACK;
                           ret_state <= shreg[0] ? ST_RDATA : ST_PTR;
                        end else begin
                           state <= ST_IDLE;
                        end
                     end else if (state == ST_PTR) begin
                        ptr <= shreg;
                        sda_pull <= 1'b1;
                        state <= ST_ACK;
                        ret_state <= ST_WDATA;
                     end else begin
                        wr_en <= 1'b1;
                        wr_data <= shreg;
                        sda_pull <= 1'b1;
                        state <= ST_ACK;
                        ret_state <= ST_WDATA;
                     end
                  end
               end
               ST_ACK: begin
                  // Acknowledge is released on the ninth falling clock
                  if (scl_fall) begin
                     sda_pull <= 1'b0;
                     if (ret_state == ST_RDATA) begin
                        shreg <= rd_data;
                        sda_pull <= ~rd_data[7];
                        bitcnt <= 4'h1;
                     end
                     state <= ret_state;
                  end
               end
               ST_RDATA: begin
                  if (scl_fall) begin
                     if (bitcnt == 4'h8) begin
                        sda_pull <= 1'b0;
                        state <= ST_RACK;
                     end else begin
                        shreg <= {shreg[6:0], 1'b0};
                        sda_pull <= ~shreg[6];
                        bitcnt <= bitcnt + 4'h1;
                     end
                  end
               end
               ST_RACK: begin
                  if (scl_rise) begin
                     ptr <= ptr + 8'h01;
                     if (sda_s) begin
                        state <= ST_IDLE;
                     end
                  end else if (scl_fall) begin
                     shreg <= rd_data;
                     sda_pull <= ~rd_data[7];
                     bitcnt <= 4'h1;
                     state <= ST_RDATA;
                  end
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
            if (wr_en) begin
               ptr <= ptr + 8'h01;
            end
         end
      end
   end

endmodule

// *** dv/oms_top_props.sv ***
// Checker for the transmit, fault, receive and management data pins of the optical module
module oms_top_props (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Transmit control and fault
   input wire tx_off_level,
   input wire tx_off_driven,
   input wire laser_fault_detect,
   input wire laser_enable,
   input wire tx_fault_oe_n,
   // Receive and management
   input wire rx_data,
   input wire receive_signal_lost,
   input wire scl_in,
   input wire sda_oe_n
);
   // An undriven pin reads high through the module pull-up
   wire pin_hi;
   logic [7:0] quiet_pin;
   logic [7:0] quiet_rx;
   assign pin_hi = tx_off_level | ~tx_off_driven;

   // Cycles since the pin or the received data last moved; saturates so it never wraps
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         quiet_pin <= 8'h00;
         quiet_rx <= 8'h00;
      end else begin
         quiet_pin <= $changed(pin_hi) ? 8'h00 : quiet_pin + {7'h00, quiet_pin != 8'hff};
         quiet_rx <= $changed(rx_data) ? 8'h00 : quiet_rx + {7'h00, quiet_rx != 8'hff};
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // ----------------------------------------------------------------
   // Transmit enable, fault latch, loss of signal, management data timing
   // ----------------------------------------------------------------
   sequence s_pin_high;
      pin_hi [*6];
   endsequence
   sequence s_fault_shut;
      tx_fault_oe_n && !laser_enable;
   endsequence
   property p_off_holds; s_pin_high |-> !laser_enable; endproperty
   a_off_holds: assert property (p_off_holds) else $error("laser on with pin high");
   property p_undriven; (!tx_off_driven) [*6] |-> !laser_enable; endproperty
   a_undriven: assert property (p_undriven) else $error("laser on with pin undriven");
   property p_on_cause; $rose(laser_enable) |-> !pin_hi && !$past(pin_hi, 2) && !tx_fault_oe_n; endproperty
   a_on_cause: assert property (p_on_cause) else $error("laser on without cause");
   property p_fault_shut; laser_fault_detect |-> ##[1:8] s_fault_shut; endproperty
   a_fault_shut: assert property (p_fault_shut) else $error("fault not shown");
   property p_fault_dark; tx_fault_oe_n [*3] |-> !laser_enable; endproperty
   a_fault_dark: assert property (p_fault_dark) else $error("laser on during fault");
   property p_fault_clear; $fell(tx_fault_oe_n) |-> quiet_pin < 8'h08; endproperty
   a_fault_clear: assert property (p_fault_clear) else $error("fault cleared without toggle");
   property p_lost_rise; quiet_rx > 8'h6e |-> receive_signal_lost; endproperty
   a_lost_rise: assert property (p_lost_rise) else $error("signal lost not raised");
   property p_lost_fall; $changed(rx_data) |-> ##[1:5] !receive_signal_lost; endproperty
   a_lost_fall: assert property (p_lost_fall) else $error("signal lost not dropped");
   property p_sda_move; $changed(sda_oe_n) |-> !scl_in; endproperty
   a_sda_move: assert property (p_sda_move) else $error("data moved with clock high");
endmodule

bind oms_top oms_top_props u_props (
   .clk(clk), .rst_n(rst_n), .tx_off_level(tx_off_level), .tx_off_driven(tx_off_driven),
   .laser_fault_detect(laser_fault_detect), .laser_enable(laser_enable), .tx_fault_oe_n(tx_fault_oe_n),
   .rx_data(rx_data), .receive_signal_lost(receive_signal_lost), .scl_in(scl_in), .sda_oe_n(sda_oe_n)
);

// *** dv/oms_host.sv ***
// Host board model: two-wire master, bus pull-ups and fault pin pull-up
module oms_host (
   // Clock
   input wire clk,
   // Module open-drain outputs
   input wire sda_oe_n,
   input wire sda_out,
   input wire tx_fault_oe_n,
   input wire tx_fault_out,
   // Resolved line levels
   output wire scl_in,
   output wire sda_in,
   output wire fault_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam real Q = 31.25;
   logic scl = 1'b1;
   logic sda = 1'b1;
   // Released lines float high through the pull-ups
   assign scl_in = scl;
   assign sda_in = sda & (sda_oe_n | sda_out);
   assign fault_pin = tx_fault_oe_n | tx_fault_out;

   // One bit in 125 ns; data moves only while the clock is low
   task automatic bit_x(input logic b, output logic r);
      sda = b;
      #Q scl = 1'b1;
      #Q r = sda_in;
      #Q scl = 1'b0;
      #Q;
   endtask
   task automatic start_c();
      sda = 1'b1;
      #Q scl = 1'b1;
      #Q sda = 1'b0;
      #Q scl = 1'b0;
      #Q;
   endtask
   task automatic stop_c();
      sda = 1'b0;
      #Q scl = 1'b1;
      #Q sda = 1'b1;
      #Q;
   endtask
   task automatic byte_x(input logic [7:0] d, input logic m, output logic [7:0] r, output logic k);
      for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
      bit_x(m, k);
   endtask
   // Byte write; nak is high when any byte went unanswered
   task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d, output logic nak);
      logic [7:0] r;
      logic k0, k1, k2;
      @(negedge clk);
      #2;
      start_c();
      byte_x({dev, 1'b0}, 1'b1, r, k0);
      byte_x(a, 1'b1, r, k1);
      byte_x(d, 1'b1, r, k2);
      stop_c();
      nak = k0 | k1 | k2;
   endtask
   // Random read: pointer write, repeated start, one byte closed by no-acknowledge
   task automatic rd(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] d, output logic nak);
      logic [7:0] r;
      logic k0, k1, k2, k3;
      @(negedge clk);
      #2;
      start_c();
      byte_x({dev, 1'b0}, 1'b1, r, k0);
      byte_x(a, 1'b1, r, k1);
      start_c();
      byte_x({dev, 1'b1}, 1'b1, r, k2);
      byte_x(8'hff, 1'b1, d, k3);
      stop_c();
      nak = k0 | k1 | k2;
   endtask
endmodule

// *** dv/oms_top_tb.sv ***
// Self-checking bench for the optical module control and management block
`include "oms_regs.vh"
module oms_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic tx_off_level = 1'b0;
   logic tx_off_driven = 1'b0;
   logic laser_fault_detect = 1'b0;
   logic rx_data = 1'b0;
   logic rx_run = 1'b0;
   logic [15:0] mon [5] = '{16'ha1b2, 16'h3c4d, 16'h5e6f, 16'h7081, 16'h92a3};
   logic [7:0] rdv;
   logic nak;
   int n_errors = 0;
   int cmp_count = 0;
   wire laser_enable, tx_fault_out, tx_fault_oe_n, receive_signal_lost;
   wire scl_in, sda_in, sda_out, sda_oe_n, fault_pin;

   oms_top DUT (
      .clk(clk), .rst_n(rst_n), .tx_off_level(tx_off_level), .tx_off_driven(tx_off_driven),
      .laser_fault_detect(laser_fault_detect), .laser_enable(laser_enable), .tx_fault_out(tx_fault_out),
      .tx_fault_oe_n(tx_fault_oe_n), .rx_data(rx_data), .receive_signal_lost(receive_signal_lost),
      .mon_temp(mon[0]), .mon_vcc(mon[1]), .mon_bias(mon[2]), .mon_tx_power(mon[3]), .mon_rx_power(mon[4]),
      .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n)
   );
   oms_host host (
      .clk(clk), .sda_oe_n(sda_oe_n), .sda_out(sda_out), .tx_fault_oe_n(tx_fault_oe_n),
      .tx_fault_out(tx_fault_out), .scl_in(scl_in), .sda_in(sda_in), .fault_pin(fault_pin)
   );

   initial begin
      forever #5 clk = ~clk;
   end
   // Incoming data keeps moving while the link is meant to be alive
   always @(negedge clk) begin
      if (rx_run) rx_data <= ~rx_data;
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Pin levels as {signal lost, fault pin, laser enable}
   task automatic pins(input logic [2:0] e);
      chk({5'h00, receive_signal_lost, fault_pin, laser_enable}, {5'h00, e});
   endtask
   task automatic rchk(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] exp);
      host.rd(dev, a, rdv, nak);
      chk({7'h00, nak}, 8'h00);
      chk(rdv, exp);
   endtask
   task automatic wchk(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d);
      host.wr(dev, a, d, nak);
      chk({7'h00, nak}, 8'h00);
   endtask
   task automatic fault_pulse();
      laser_fault_detect = 1'b1;
      cyc(3);
      laser_fault_detect = 1'b0;
      cyc(10);
   endtask
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Watchdog well beyond the expected run of about 110 us
   initial begin
      #400us;
      n_errors++;
      close_out();
   end

   initial begin
      cyc(16);
      rst_n = 1'b1;
      cyc(8);
      pins(3'b100);
      rchk(`OMS_DEV_DIAG, `OMS_CTRL_STATUS, 8'h82);
      $display("Test power-up done");
      tx_off_driven = 1'b1;
      rx_run = 1'b1;
      cyc(10);
      pins(3'b001);
      rchk(`OMS_DEV_DIAG, `OMS_CTRL_STATUS, 8'h00);
      tx_off_level = 1'b1;
      cyc(10);
      pins(3'b000);
      wchk(`OMS_DEV_DIAG, `OMS_CTRL_STATUS, 8'hff);
      rchk(`OMS_DEV_DIAG, `OMS_CTRL_STATUS, 8'hc0);
      wchk(`OMS_DEV_DIAG, `OMS_CTRL_STATUS, 8'h00);
      pins(3'b000);
      tx_off_level = 1'b0;
      cyc(10);
      pins(3'b001);
      wchk(`OMS_DEV_DIAG, `OMS_CTRL_STATUS, 8'h40);
      pins(3'b000);
      wchk(`OMS_DEV_DIAG, `OMS_CTRL_STATUS, 8'h00);
      pins(3'b001);
      $display("Test transmit-off done");
      fault_pulse();
      pins(3'b010);
      rchk(`OMS_DEV_DIAG, `OMS_CTRL_STATUS, 8'h04);
      cyc(60);
      pins(3'b010);
      tx_off_level = 1'b1;
      cyc(10);
      tx_off_level = 1'b0;
      cyc(10);
      pins(3'b001);
      fault_pulse();
      rst_n = 1'b0;
      cyc(2);
      rst_n = 1'b1;
      cyc(8);
      pins(3'b001);
      $display("Test fault done");
      rx_run = 1'b0;
      cyc(120);
      pins(3'b101);
      rchk(`OMS_DEV_DIAG, `OMS_CTRL_STATUS, 8'h02);
      rx_run = 1'b1;
      cyc(5);
      pins(3'b001);
      $display("Test signal lost done");
      wchk(`OMS_DEV_ID, 8'h10, 8'h5a);
      wchk(`OMS_DEV_DIAG, 8'h10, 8'ha5);
      rchk(`OMS_DEV_ID, 8'h10, 8'h5a);
      rchk(`OMS_DEV_DIAG, 8'h10, 8'ha5);
      host.wr(7'h52, 8'h10, 8'h00, nak);
      chk({7'h00, nak}, 8'h01);
      for (int i = 0; i < 5; i++) begin
         rchk(`OMS_DEV_DIAG, `OMS_TEMP_MSB + 8'(2 * i), mon[i][15:8]);
         rchk(`OMS_DEV_DIAG, `OMS_TEMP_MSB + 8'(2 * i + 1), mon[i][7:0]);
      end
      $display("Test pages done");
      close_out();
   end
endmodule
